// ---- rtl/aicm_map.svh ----
`ifndef AICM_MAP_SVH
`define AICM_MAP_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define AICM_OFF_SEL      8'h00
`define AICM_OFF_STAT     8'h04
`define AICM_OFF_OUT      8'h10
`define AICM_OFF_JMP      8'h20
`define AICM_OFF_JMP_END  8'h38
`define AICM_OFF_CRV      8'h40
`define AICM_OFF_CRV_END  8'he0
// ----------------------------------------
// Limits: volts in 10 mV, settings in 0.1 %
// ----------------------------------------
`define AICM_VMIN         16'shfc18
`define AICM_VMAX         16'sh03e8
`define AICM_SMIN         16'shfc18
`define AICM_SMAX         16'sh03e8
`define AICM_AMIN         16'sh0000
// ----------------------------------------
// Reset values
// ----------------------------------------
`define AICM_RST_P0       16'sh0000
`define AICM_RST_P1       16'sh012c
`define AICM_RST_P2       16'sh0258
`define AICM_RST_P3       16'sh03e8
`define AICM_RST_JPT      16'sh0000
`define AICM_RST_JAMP     16'sh0005
`define AICM_RST_SEL      9'h0d1
`define AICM_NUM_LINES    3'h3
`define AICM_DIV_STEPS    5'h18
`define AICM_RESP_OK      2'h0
`define AICM_RESP_ERR     2'h2
`endif

// ---- rtl/aicm_pkg.sv ----
package aicm_pkg;
	// Sequencer states of the mapping engine
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SEG,
		ST_DIV,
		ST_JUMP,
		ST_OUT
	} aicm_state_type;
	// Signed voltage (10 mV) or setting (0.1 %)
	typedef logic signed [15:0] aicm_val_type;
endpackage

// ---- rtl/aicm_mapper.sv ----
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
`include "aicm_map.svh"

// ----------------------------------------
// Sample FIFO
// ----------------------------------------
module aicm_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 4
) (
	input  wire logic             ref_clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wp_q, rp_q;
	logic [CW-1:0]    cnt_q, cnt_d;
	logic             rdy_q;
	wire              push = in_valid & rdy_q;
	wire              pop  = out_valid & out_ready;

	// Ready is registered so the source sees back-pressure from a flop
	assign cnt_d     = cnt_q + CW'(push) - CW'(pop);
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rp_q];
	assign in_ready  = rdy_q;

	// Pointers and count
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
			rdy_q <= 1'b1;
		end else begin
			if (push)
				wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
			cnt_q <= cnt_d;
			rdy_q <= (cnt_d < CW'(DEPTH));
		end
	end

	// Storage needs no reset
	always_ff @(posedge ref_clk) begin
		if (push)
			mem_q[wp_q] <= in_data;
	end
endmodule // aicm_fifo

// ----------------------------------------
// Curve mapper
// ----------------------------------------
// Summary of operation
// - Curve four has four points, defaults 0/3/6/10 V to 0/30/60/100 %.
// - Curve five has its own four points with the same defaults.
// - Point volts stay in +-10 V and between neighbouring points.
// - Point settings are signed, -100.0 % to 100.0 %, 0.1 % steps.
// - Curves one to three are lines; four and five are four-point curves.
// - Each of the three inputs selects its own curve.
// - Setting within +-amplitude of the jump point outputs the jump point.
// - Jump point -100..100 % default 0; amplitude 0..100 % default 0.5 %.
module aicm_mapper (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        smp_valid,
	output logic             smp_ready,
	input  wire logic [1:0]  smp_input,
	input  wire logic [15:0] smp_volt,
	output logic             set_valid,
	input  wire logic        set_ready,
	output logic [1:0]       set_input,
	output logic [15:0]      set_value
);
	aicm_pkg::aicm_val_type vol_q [20];
	aicm_pkg::aicm_val_type pct_q [20];
	aicm_pkg::aicm_val_type jpt_q [3];
	aicm_pkg::aicm_val_type jamp_q [3];
	aicm_pkg::aicm_val_type res_q [3];
	logic [8:0]             sel_q;
	aicm_pkg::aicm_state_type st_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        aw_have_q, w_have_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic        set_valid_q;
	logic [1:0]  set_input_q, ch_q;

	// ----------------------------------------
	// Bus write decode
	// ----------------------------------------
	wire        wr_fire  = aw_have_q & w_have_q & ~bvalid_q;
	wire        wr_full  = (wstrb_q[1:0] == 2'h3);
	wire [7:0]  wcrv_off = awaddr_q - `AICM_OFF_CRV;
	wire [7:0]  wjmp_off = awaddr_q - `AICM_OFF_JMP;
	wire        wr_crv   = (awaddr_q >= `AICM_OFF_CRV) && (awaddr_q < `AICM_OFF_CRV_END);
	wire        wr_jmp   = (awaddr_q >= `AICM_OFF_JMP) && (awaddr_q < `AICM_OFF_JMP_END);
	wire        wr_sel   = (awaddr_q == `AICM_OFF_SEL);
	wire        wr_ok    = wr_crv | wr_jmp | wr_sel | (awaddr_q == `AICM_OFF_STAT)
	                     | ((awaddr_q >= `AICM_OFF_OUT) && (awaddr_q < `AICM_OFF_JMP));
	wire [4:0]  wcrv_idx = wcrv_off[7:3];
	wire [1:0]  wjmp_idx = wjmp_off[4:3];
	wire        wr_en    = wr_fire & wr_full;
	wire signed [15:0] wval = wdata_q[15:0]; // Low half carries the signed value

	function automatic logic signed [15:0] sat(input logic signed [15:0] v,
	                                           input logic signed [15:0] lo,
	                                           input logic signed [15:0] hi);
		return (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// Curve point registers, one entry per point of each curve
	for (genvar k = 0; k < 20; k++) begin : g_pt
		localparam int P = k % 4;
		localparam int KL = (P == 0) ? k : k - 1;
		localparam int KH = (P == 3) ? k : k + 1;
		wire signed [15:0] lo = (P == 0) ? `AICM_VMIN : vol_q[KL];
		wire signed [15:0] hi = (P == 3) ? `AICM_VMAX : vol_q[KH];
		wire               hit = wr_en & wr_crv & (wcrv_idx == 5'(k));
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				vol_q[k] <= (P == 0) ? `AICM_RST_P0 : (P == 1) ? `AICM_RST_P1 :
				            (P == 2) ? `AICM_RST_P2 : `AICM_RST_P3;
				pct_q[k] <= (P == 0) ? `AICM_RST_P0 : (P == 1) ? `AICM_RST_P1 :
				            (P == 2) ? `AICM_RST_P2 : `AICM_RST_P3;
			end else if (hit && !awaddr_q[2]) begin
				vol_q[k] <= sat(wval, lo, hi);
			end else if (hit) begin
				pct_q[k] <= sat(wval, `AICM_SMIN, `AICM_SMAX);
			end
		end
	end

	// Jump point and amplitude per input
	for (genvar j = 0; j < 3; j++) begin : g_jmp
		wire hit = wr_en & wr_jmp & (wjmp_idx == 2'(j));
		always_ff @(posedge ref_clk) begin
			if (rst) begin
				jpt_q[j]  <= `AICM_RST_JPT;
				jamp_q[j] <= `AICM_RST_JAMP;
			end else if (hit && !awaddr_q[2]) begin
				jpt_q[j] <= sat(wval, `AICM_SMIN, `AICM_SMAX);
			end else if (hit) begin
				jamp_q[j] <= sat(wval, `AICM_AMIN, `AICM_SMAX);
			end
		end
	end

	// Curve selection, one 3-bit field per input; a write holding any out-of-range code is ignored
	wire [2:0] sf0 = wdata_q[2:0];
	wire [2:0] sf1 = wdata_q[5:3];
	wire [2:0] sf2 = wdata_q[8:6];
	wire       sel_good = (sf0 != 3'h0) && (sf0 < 3'h6) && (sf1 != 3'h0) && (sf1 < 3'h6)
	                   && (sf2 != 3'h0) && (sf2 < 3'h6);
	always_ff @(posedge ref_clk) begin
		if (rst)
			sel_q <= `AICM_RST_SEL;
		else if (wr_fire && wr_sel && wstrb_q[1:0] == 2'h3 && sel_good)
			sel_q <= wdata_q[8:0];
	end

	// ----------------------------------------
	// Bus handshakes
	// ----------------------------------------
	// Address and data are taken in either order; the answer waits for both
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= `AICM_RESP_OK;
			awaddr_q  <= '0;
			wdata_q   <= '0;
			wstrb_q   <= '0;
		end else begin
			if (s_axi_awvalid && !aw_have_q) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_q) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata;
				wstrb_q  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wr_ok ? `AICM_RESP_OK : `AICM_RESP_ERR;
			end else if (bvalid_q && s_axi_bready) begin
				bvalid_q  <= 1'b0;
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
			end
		end
	end

	// Read decode
	wire [7:0] rcrv_off = s_axi_araddr - `AICM_OFF_CRV;
	wire [7:0] rjmp_off = s_axi_araddr - `AICM_OFF_JMP;
	wire [7:0] rout_off = s_axi_araddr - `AICM_OFF_OUT;
	wire       rd_crv = (s_axi_araddr >= `AICM_OFF_CRV) && (s_axi_araddr < `AICM_OFF_CRV_END);
	wire       rd_jmp = (s_axi_araddr >= `AICM_OFF_JMP) && (s_axi_araddr < `AICM_OFF_JMP_END);
	wire       rd_out = (s_axi_araddr >= `AICM_OFF_OUT) && (rout_off[7:2] < 6'h3);
	wire       rd_sel = (s_axi_araddr == `AICM_OFF_SEL);
	wire       rd_st  = (s_axi_araddr == `AICM_OFF_STAT);
	wire       rd_hit = rd_crv | rd_jmp | rd_out | rd_sel | rd_st;
	wire [15:0] crv_rd = s_axi_araddr[2] ? pct_q[rcrv_off[7:3]] : vol_q[rcrv_off[7:3]];
	wire [15:0] jmp_rd = s_axi_araddr[2] ? jamp_q[rjmp_off[4:3]] : jpt_q[rjmp_off[4:3]];
	wire [31:0] rd_val = rd_crv ? {16'h0000, crv_rd}
	                   : rd_jmp ? {16'h0000, jmp_rd}
	                   : rd_out ? {16'h0000, res_q[rout_off[3:2]]}
	                   : rd_sel ? {23'h000000, sel_q}
	                   : rd_st  ? {31'h00000000, st_q != aicm_pkg::ST_IDLE}
	                   : 32'h00000000;

	// Read answer one cycle after the address is taken
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rdata_q   <= '0;
			rresp_q   <= `AICM_RESP_OK;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_val;
			rresp_q   <= rd_hit ? `AICM_RESP_OK : `AICM_RESP_ERR;
		end else if (rvalid_q && s_axi_rready) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end
	end

	// ----------------------------------------
	// Sample path
	// ----------------------------------------
	logic        fo_valid;
	logic [17:0] fo_data;
	wire         fo_pop = (st_q == aicm_pkg::ST_IDLE) & fo_valid;
	aicm_fifo #(.WIDTH(18), .DEPTH(4)) u_fifo (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.in_valid  (smp_valid),
		.in_ready  (smp_ready),
		.in_data   ({smp_input, smp_volt}),
		.out_valid (fo_valid),
		.out_ready (fo_pop),
		.out_data  (fo_data)
	);

	aicm_pkg::aicm_val_type x_q, y_q, y0_q;
	logic [11:0] dx_q, rem_q;
	logic [23:0] dvd_q;
	logic        neg_q;
	logic [4:0]  cnt_q;
	logic [15:0] set_value_q;

	// Segment choice for the curve this input selects
	wire [2:0]  selc = (ch_q == 2'h0) ? sel_q[2:0] : (ch_q == 2'h1) ? sel_q[5:3] : sel_q[8:6];
	wire [2:0]  ci   = selc - 3'h1;
	wire [4:0]  base = {ci, 2'h0};
	wire        line = (ci < `AICM_NUM_LINES);
	wire signed [15:0] v0 = vol_q[base];
	wire signed [15:0] v1 = vol_q[base + 5'h1];
	wire signed [15:0] v2 = vol_q[base + 5'h2];
	wire signed [15:0] v3 = vol_q[base + 5'h3];
	wire        below = (x_q <= v0);
	wire        above = (x_q >= v3);
	wire [1:0]  sa = line ? 2'h0 : (x_q < v1) ? 2'h0 : (x_q < v2) ? 2'h1 : 2'h2;
	wire [1:0]  sb = line ? 2'h3 : sa + 2'h1;
	wire signed [15:0] xa = vol_q[base + 5'(sa)];
	wire signed [15:0] xb = vol_q[base + 5'(sb)];
	wire signed [15:0] ya = pct_q[base + 5'(sa)];
	wire signed [15:0] yb = pct_q[base + 5'(sb)];
	wire signed [16:0] dy = 17'(yb) - 17'(ya);
	wire [15:0] dy_mag = dy[16] ? 16'(-dy) : dy[15:0];
	wire [15:0] dxs    = 16'(17'(x_q) - 17'(xa));
	wire [31:0] prod   = dy_mag * dxs; // Below 2^22 while x lies inside the segment
	wire [15:0] dxw    = 16'(17'(xb) - 17'(xa));

	// One restoring divide step per cycle
	wire [12:0] trial = {rem_q, dvd_q[23]};
	wire        ge    = (trial >= {1'b0, dx_q});
	wire [12:0] rem_n = ge ? trial - {1'b0, dx_q} : trial;

	// Jump band check on the mapped value
	wire signed [15:0] jp  = jpt_q[ch_q];
	wire signed [16:0] jd  = 17'(y_q) - 17'(jp);
	wire signed [16:0] ja  = 17'(jamp_q[ch_q]);
	wire        in_band = (jd <= ja) && (jd >= -ja);

	// Mapping sequencer
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st_q <= aicm_pkg::ST_IDLE;
			ch_q <= '0; x_q <= '0; y_q <= '0; y0_q <= '0;
			dx_q <= '0; rem_q <= '0; dvd_q <= '0; neg_q <= 1'b0; cnt_q <= '0;
			set_valid_q <= 1'b0; set_input_q <= '0; set_value_q <= '0;
			res_q <= '{default: 16'sh0000};
		end else begin
			case (st_q)
				aicm_pkg::ST_IDLE: if (fo_valid && fo_data[17:16] != 2'h3) begin
					ch_q <= fo_data[17:16];
					x_q  <= fo_data[15:0];
					st_q <= aicm_pkg::ST_SEG;
				end
				aicm_pkg::ST_SEG: begin
					if (below) begin
						y_q  <= pct_q[base];
						st_q <= aicm_pkg::ST_JUMP;
					end else if (above) begin
						y_q  <= pct_q[base + 5'h3];
						st_q <= aicm_pkg::ST_JUMP;
					end else begin
						y0_q  <= ya;
						neg_q <= dy[16];
						dx_q  <= dxw[11:0];
						dvd_q <= prod[23:0];
						rem_q <= '0;
						cnt_q <= '0;
						st_q  <= aicm_pkg::ST_DIV;
					end
				end
				aicm_pkg::ST_DIV: begin
					rem_q <= rem_n[11:0];
					dvd_q <= {dvd_q[22:0], ge};
					cnt_q <= cnt_q + 5'h1;
					if (cnt_q == `AICM_DIV_STEPS - 5'h1)
						st_q <= aicm_pkg::ST_JUMP;
				end
				aicm_pkg::ST_JUMP: begin
					// Pin to the jump point when the mapped value sits in the band
					set_value_q <= in_band ? jp : y_q;
					res_q[ch_q] <= in_band ? jp : y_q;
					set_input_q <= ch_q;
					set_valid_q <= 1'b1;
					st_q        <= aicm_pkg::ST_OUT;
				end
				aicm_pkg::ST_OUT: if (set_ready) begin
					set_valid_q <= 1'b0;
					st_q        <= aicm_pkg::ST_IDLE;
				end
				default: st_q <= aicm_pkg::ST_IDLE;
			endcase
			if (st_q == aicm_pkg::ST_DIV && cnt_q == `AICM_DIV_STEPS - 5'h1)
				y_q <= neg_q ? y0_q - {dvd_q[14:0], ge} : y0_q + {dvd_q[14:0], ge};
		end
	end

	assign s_axi_awready = ~aw_have_q;
	assign s_axi_wready  = ~w_have_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign set_valid     = set_valid_q;
	assign set_input     = set_input_q;
	assign set_value     = set_value_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	chk_jump_pin: assert property ((st_q == aicm_pkg::ST_JUMP && in_band) |=>
		set_valid && set_value == $past(jp)) else $error("in-band value not pinned");
	chk_jump_pass: assert property ((st_q == aicm_pkg::ST_JUMP && !in_band) |=>
		set_value == $past(y_q)) else $error("out-of-band value altered");
	chk_clamp_low: assert property ((st_q == aicm_pkg::ST_SEG && below) |=>
		y_q == $past(pct_q[base]) ##1 st_q == aicm_pkg::ST_OUT)
		else $error("low clamp wrong");
	chk_div_len: assert property ((st_q == aicm_pkg::ST_SEG && !below && !above) |=>
		(st_q == aicm_pkg::ST_DIV) [*8] ##17 st_q == aicm_pkg::ST_JUMP)
		else $error("divide length wrong");
	chk_pt_order: assert property (vol_q[12] <= vol_q[13] && vol_q[13] <= vol_q[14]
		&& vol_q[14] <= vol_q[15] && vol_q[15] <= `AICM_VMAX) else $error("curve order");
	chk_pct_range: assert property (pct_q[16] >= `AICM_SMIN && pct_q[19] <= `AICM_SMAX)
		else $error("setting out of range");
	chk_amp_range: assert property (jamp_q[0] >= `AICM_AMIN && jamp_q[0] <= `AICM_SMAX)
		else $error("amplitude out of range");
	chk_sel_range: assert property (sel_q[2:0] != 3'h0 && sel_q[2:0] < 3'h6)
		else $error("curve select out of range");
	chk_out_hold: assert property ((set_valid && !set_ready) |=>
		set_valid && $stable(set_value) && $stable(set_input)) else $error("output dropped");
	chk_write_resp: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready && !bvalid_q) |=> ##1 s_axi_bvalid) else $error("no write response");
endmodule // aicm_mapper

// ---- dv/aicm_smp_src.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Sample source model
// ----------------------------------------
module aicm_smp_src (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic smp_ready,
	output logic      smp_valid,
	output logic [1:0]  smp_input,
	output logic [15:0] smp_volt
);
	logic [17:0] pend_q[$];
	initial begin
		smp_valid = 1'b0;
		smp_input = 2'h0;
		smp_volt  = 16'h0000;
	end
	// Queue one conversion result for delivery
	task push(input logic [1:0] i, input logic [15:0] v);
		pend_q.push_back({i, v});
	endtask
	// Hold each sample until taken; idle lines toggle so stale data never looks valid
	always @(posedge ref_clk) begin
		if (rst) begin
			smp_valid <= 1'b0;
		end else if (!smp_valid || smp_ready) begin
			if (pend_q.size() > 0) begin
				{smp_input, smp_volt} <= pend_q.pop_front();
				smp_valid <= 1'b1;
			end else begin
				smp_valid <= 1'b0;
				smp_input <= ~smp_input;
				smp_volt  <= ~smp_volt;
			end
		end
	end
endmodule // aicm_smp_src

// ---- dv/aicm_mapper_tb.sv ----
`timescale 1ns/10ps
// ----------------------------------------
// Curve mapper testbench
// ----------------------------------------
module aicm_mapper_tb;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, set_ready = 1'b1;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic [3:0]  wstrb = 4'hf;
	logic        awready, wready, bvalid, arready, rvalid, smp_ready, smp_valid, set_valid;
	logic [1:0]  bresp, rresp, smp_input, set_input;
	logic [15:0] smp_volt, set_value;
	int          num_errors = 0, tests_run = 0;
	int          dv[4] = '{0, 300, 600, 1000};

	aicm_mapper u_dut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(1'b1), .smp_valid(smp_valid), .smp_ready(smp_ready),
		.smp_input(smp_input), .smp_volt(smp_volt), .set_valid(set_valid),
		.set_ready(set_ready), .set_input(set_input), .set_value(set_value));
	aicm_smp_src u_src (.ref_clk(ref_clk), .rst(rst), .smp_ready(smp_ready),
		.smp_valid(smp_valid), .smp_input(smp_input), .smp_volt(smp_volt));

	initial begin
		forever #50 ref_clk = ~ref_clk;
	end
	task check(string what, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// Write both channels together; bready stays high so the response is taken at once
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge ref_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		check("b_wait", 32'(n < 200), 32'h1);
		check("bresp", bresp, er);
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge ref_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		check("r_wait", 32'(n < 200), 32'h1);
		check("rdata", rdata, e);
		check("rresp", rresp, er);
	endtask
	// Wait for one mapped setting, bounded
	task get_set(input logic [1:0] ei, input logic [15:0] ev);
		int n;
		for (n = 0; n < 200; n++) begin
			@(posedge ref_clk);
			if (set_valid && set_ready) break;
		end
		check("set_wait", 32'(n < 200), 32'h1);
		check("set_input", set_input, ei);
		check("set_value", set_value, ev);
	endtask
	task t_defaults;
		for (int c = 0; c < 5; c++) begin
			for (int p = 0; p < 4; p++) begin
				rd_chk(8'(8'h40 + 32 * c + 8 * p), dv[p], 2'h0);
				rd_chk(8'(8'h44 + 32 * c + 8 * p), dv[p], 2'h0);
			end
		end
		for (int i = 0; i < 3; i++) begin
			rd_chk(8'(8'h20 + 8 * i), 32'h0, 2'h0);
			rd_chk(8'(8'h24 + 8 * i), 32'h5, 2'h0);
		end
		rd_chk(8'h00, 32'h0d1, 2'h0);
		rd_chk(8'h04, 32'h0, 2'h0);
		rd_chk(8'h08, 32'h0, 2'h2);
		wr(8'h08, 32'h1, 2'h2);
	endtask
	// Point writes beyond neighbours or range are pulled back
	task t_clamp;
		wr(8'ha8, 32'd700, 2'h0);
		rd_chk(8'ha8, 32'd600, 2'h0);
		wr(8'hb8, 32'd1200, 2'h0);
		rd_chk(8'hb8, 32'd1000, 2'h0);
		wr(8'ha0, 32'h0000fa24, 2'h0);
		rd_chk(8'ha0, 32'h0000fc18, 2'h0);
		wr(8'hac, 32'd1500, 2'h0);
		rd_chk(8'hac, 32'd1000, 2'h0);
		wr(8'ha0, 32'd0, 2'h0);
		wr(8'ha8, 32'd300, 2'h0);
		wr(8'hac, 32'h0000ff38, 2'h0);
		rd_chk(8'hac, 32'h0000ff38, 2'h0);
	endtask
	task t_select;
		wr(8'h00, 32'h0ec, 2'h0);
		rd_chk(8'h00, 32'h0ec, 2'h0);
		wr(8'h00, 32'h0e8, 2'h0);
		wr(8'h00, 32'h1ff, 2'h0);
		rd_chk(8'h00, 32'h0ec, 2'h0);
		// A write without the low lanes is ignored
		wstrb <= 4'hc;
		wr(8'h00, 32'h0d1, 2'h0);
		wstrb <= 4'hf;
		rd_chk(8'h00, 32'h0ec, 2'h0);
	endtask
	// Input one on reshaped curve four, two on curve five, three on line three
	task t_map;
		logic [1:0]  ti[8] = '{0, 0, 0, 0, 1, 2, 2, 0};
		logic [15:0] tv[8] = '{150, 450, -50, 1200, 450, 250, -300, 300};
		logic [15:0] te[8] = '{-100, 200, 0, 1000, 450, 250, 0, -200};
		u_src.push(2'h3, 16'd500); // Input code 3 is dropped, never answered
		for (int k = 0; k < 8; k++) begin
			u_src.push(ti[k], tv[k]);
			get_set(ti[k], te[k]);
		end
		wr(8'h10, 32'h7, 2'h0);
		rd_chk(8'h10, 32'h0000ff38, 2'h0);
		rd_chk(8'h14, 32'd450, 2'h0);
		rd_chk(8'h18, 32'd0, 2'h0);
	endtask
	// Mapped 213 against point 200: edge of band is inside
	task t_jump;
		wr(8'h20, 32'd200, 2'h0);
		wr(8'h24, 32'd13, 2'h0);
		u_src.push(2'h0, 16'd455);
		get_set(2'h0, 16'd200);
		wr(8'h24, 32'd12, 2'h0);
		u_src.push(2'h0, 16'd455);
		get_set(2'h0, 16'd213);
		wr(8'h24, 32'd1500, 2'h0);
		rd_chk(8'h24, 32'd1000, 2'h0);
		u_src.push(2'h0, 16'd150);
		get_set(2'h0, 16'd200);
		wr(8'h28, 32'h0000fa24, 2'h0);
		rd_chk(8'h28, 32'h0000fc18, 2'h0);
	endtask
	// Stall the output so the sample FIFO fills and refuses
	task t_fifo;
		set_ready <= 1'b0;
		for (int k = 1; k <= 6; k++) u_src.push(2'h2, 16'(100 * k));
		for (int n = 0; n < 400 && smp_ready; n++) @(posedge ref_clk);
		check("smp_ready", smp_ready, 1'b0);
		rd_chk(8'h04, 32'h1, 2'h0);
		set_ready <= 1'b1;
		for (int k = 1; k <= 6; k++) get_set(2'h2, 16'(100 * k));
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		t_defaults;
		t_clamp;
		t_select;
		t_map;
		t_jump;
		t_fifo;
		give_verdict;
	end
	// Runs take under a thousand cycles
	initial begin
		#(100 * 20000);
		num_errors++;
		give_verdict;
	end
endmodule // aicm_mapper_tb
